// ==== rtl/tig_irq_group.sv ====
/*
 * timer interrupt group status and mask registers: sticky request flags,
 * block bits and one request line per group toward the interrupt
 * controller. Assumes request inputs synchronous to i_clk, one-cycle
 * register strobes, and tig_pkg compiled first.
 */
// The plain strobed port was decided locally.
//
// Contract
// - status reads 1 after request, else 0
// - writing 0 clears status, 1 keeps
// - mask bit 0 passes, 1 blocks request
// - reserved capture mask bits read zero
// - pulse channel ten has no bits here
// - pulse 9/8 status and mask positions
// - io 3..0 status and mask layout
// - io 7..4 status and mask layout
// - io 9/8 status and mask positions
// - measure 1/0 status and mask positions
// - capture 0 status and mask positions
// - capture 3 status and mask positions
// - capture 19..16 status, lower nibble empty
// - only hardware requests set status bits
// - status records requests even while masked
`timescale 1ns/1ps
`default_nettype none
`include "tig_regs.svh"

module tig_irq_group (
	input  wire logic                   i_clk,           // 125 MHz clock
	input  wire logic                   i_arst_n,        // async reset, low
	input  wire logic                   i_ce,            // clock enable
	input  wire logic [`TIG_ADDR_W-1:0] i_addr,          // byte address
	input  wire logic [`TIG_DATA_W-1:0] i_wdata,         // write data
	input  wire logic                   i_wr,            // write strobe
	input  wire logic                   i_rd,            // read strobe
	output logic      [`TIG_DATA_W-1:0] o_rdata,         // read data
	input  wire logic [1:0]             i_pulse_req,     // pulse ch 9..8
	input  wire logic [9:0]             i_io_req,        // io ch 9..0
	input  wire logic [1:0]             i_measure_req,   // measure ch 1..0
	input  wire logic                   i_capture0_req,  // capture ch 0
	input  wire logic                   i_capture3_req,  // capture ch 3
	input  wire logic [3:0]             i_capture_hi_req,// capture 19..16
	output logic                        o_irq_pulse_89,  // pulse 8,9 group
	output logic                        o_irq_io_0_3,    // io 0..3 group
	output logic                        o_irq_io_4_7,    // io 4..7 group
	output logic                        o_irq_io_8_9,    // io 8,9 group
	output logic                        o_irq_measure,   // measure group
	output logic                        o_irq_capture0,  // capture 0
	output logic                        o_irq_capture3,  // capture 3
	output logic                        o_irq_capture_hi // capture 16..19
);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	tig_pkg::tig_state_s r;
	tig_pkg::tig_state_s next_r;

	logic [`TIG_NSRC-1:0] req;      // request per source
	logic [`TIG_NSRC-1:0] clr;      // clear per source from a write
	logic [`TIG_NSRC-1:0] next_sts; // sticky update per source

	// -----------------------------------------------------------------
	// request vector
	// -----------------------------------------------------------------
	// channel ten of the pulse timers is not a source of this block:
	// its lone request goes straight to the interrupt controller
	assign req = {i_capture_hi_req, i_capture3_req, i_capture0_req,
		i_measure_req, i_io_req, i_pulse_req};

	// -----------------------------------------------------------------
	// write clear decode
	// -----------------------------------------------------------------
	// a zero written at a status position clears it, a one is ignored
	always_comb begin
		clr = '0;
		if (i_wr) begin
			unique case (i_addr)
				`TIG_PULSE_D_ADDR: begin
					clr[`TIG_SRC_PULSE +: 2] =
						~i_wdata[`TIG_PAIR_STS_LSB +: 2];
				end
				`TIG_IO_A_ADDR: begin
					clr[`TIG_SRC_IO +: 4] =
						~i_wdata[`TIG_QUAD_STS_LSB +: 4];
				end
				`TIG_IO_B_ADDR: begin
					clr[`TIG_SRC_IO_B +: 4] =
						~i_wdata[`TIG_QUAD_STS_LSB +: 4];
				end
				`TIG_IO_C_ADDR: begin
					clr[`TIG_SRC_IO_C +: 2] =
						~i_wdata[`TIG_PAIR_STS_LSB +: 2];
				end
				`TIG_MEAS_ADDR: begin
					clr[`TIG_SRC_MEAS +: 2] =
						~i_wdata[`TIG_PAIR_STS_LSB +: 2];
				end
				`TIG_CAP_A_ADDR: begin
					clr[`TIG_SRC_CAP0] =
						~i_wdata[`TIG_ONE_STS_BIT];
				end
				`TIG_CAP_B_ADDR: begin
					clr[`TIG_SRC_CAP3] =
						~i_wdata[`TIG_ONE_STS_BIT];
				end
				`TIG_CAP_E_ADDR: begin
					clr[`TIG_SRC_CAPHI +: 4] =
						~i_wdata[`TIG_QUAD_STS_LSB +: 4];
				end
				default: begin
					clr = '0; // unmapped address, nothing happens
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// sticky flags, one per source
	// -----------------------------------------------------------------
	// the request wins over a clear in the same cycle so that no event
	// is lost; masks are not consulted, so software can poll a blocked
	// channel; no write path can set a flag
	genvar g;
	generate
		for (g = 0; g < `TIG_NSRC; g = g + 1) begin : g_src
			assign next_sts[g] =
				req[g] | (r.sts[g] & ~clr[g]);
		end
	endgenerate

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		next_r       = r;
		next_r.sts   = next_sts;
		next_r.rdata = `TIG_BYTE_ZERO;

		// mask writes are plain stores; reserved mask positions and
		// unassigned bits are dropped on the floor
		if (i_wr) begin
			unique case (i_addr)
				`TIG_PULSE_D_ADDR: begin
					next_r.blk[`TIG_SRC_PULSE +: 2] =
						i_wdata[`TIG_PAIR_BLK_LSB +: 2];
				end
				`TIG_IO_A_ADDR: begin
					next_r.blk[`TIG_SRC_IO +: 4] =
						i_wdata[`TIG_QUAD_BLK_LSB +: 4];
				end
				`TIG_IO_B_ADDR: begin
					next_r.blk[`TIG_SRC_IO_B +: 4] =
						i_wdata[`TIG_QUAD_BLK_LSB +: 4];
				end
				`TIG_IO_C_ADDR: begin
					next_r.blk[`TIG_SRC_IO_C +: 2] =
						i_wdata[`TIG_PAIR_BLK_LSB +: 2];
				end
				`TIG_MEAS_ADDR: begin
					next_r.blk[`TIG_SRC_MEAS +: 2] =
						i_wdata[`TIG_PAIR_BLK_LSB +: 2];
				end
				`TIG_CAP_A_ADDR: begin
					// bits 2 and 1 take the write but store nothing
					next_r.blk[`TIG_SRC_CAP0] =
						i_wdata[`TIG_ONE_BLK_BIT];
				end
				`TIG_CAP_B_ADDR: begin
					// bits 3..1 take the write but store nothing
					next_r.blk[`TIG_SRC_CAP3] =
						i_wdata[`TIG_ONE_BLK_BIT];
				end
				default: begin
					next_r.blk = r.blk; // no mask at this address
				end
			endcase
		end

		// read answer shows the stored state, unassigned bits as zero
		if (i_rd) begin
			unique case (i_addr)
				`TIG_PULSE_D_ADDR: begin
					next_r.rdata = {2'h0, r.sts[`TIG_SRC_PULSE +: 2],
						2'h0, r.blk[`TIG_SRC_PULSE +: 2]};
				end
				`TIG_IO_A_ADDR: begin
					next_r.rdata = {r.sts[`TIG_SRC_IO +: 4],
						r.blk[`TIG_SRC_IO +: 4]};
				end
				`TIG_IO_B_ADDR: begin
					next_r.rdata = {r.sts[`TIG_SRC_IO_B +: 4],
						r.blk[`TIG_SRC_IO_B +: 4]};
				end
				`TIG_IO_C_ADDR: begin
					next_r.rdata = {2'h0, r.sts[`TIG_SRC_IO_C +: 2],
						2'h0, r.blk[`TIG_SRC_IO_C +: 2]};
				end
				`TIG_MEAS_ADDR: begin
					next_r.rdata = {2'h0, r.sts[`TIG_SRC_MEAS +: 2],
						2'h0, r.blk[`TIG_SRC_MEAS +: 2]};
				end
				`TIG_CAP_A_ADDR: begin
					next_r.rdata = {3'h0, r.sts[`TIG_SRC_CAP0],
						3'h0, r.blk[`TIG_SRC_CAP0]};
				end
				`TIG_CAP_B_ADDR: begin
					next_r.rdata = {3'h0, r.sts[`TIG_SRC_CAP3],
						3'h0, r.blk[`TIG_SRC_CAP3]};
				end
				`TIG_CAP_E_ADDR: begin
					next_r.rdata = {r.sts[`TIG_SRC_CAPHI +: 4],
						4'h0};
				end
				default: begin
					next_r.rdata = `TIG_BYTE_ZERO; // unmapped reads zero
				end
			endcase
		end

		// group requests come from the next flags and masks so that the
		// line moves in the same edge as the flag it depends on
		next_r.irq[0] = |(next_sts[`TIG_SRC_PULSE +: 2] &
			~next_r.blk[`TIG_SRC_PULSE +: 2]);
		next_r.irq[1] = |(next_sts[`TIG_SRC_IO +: 4] &
			~next_r.blk[`TIG_SRC_IO +: 4]);
		next_r.irq[2] = |(next_sts[`TIG_SRC_IO_B +: 4] &
			~next_r.blk[`TIG_SRC_IO_B +: 4]);
		next_r.irq[3] = |(next_sts[`TIG_SRC_IO_C +: 2] &
			~next_r.blk[`TIG_SRC_IO_C +: 2]);
		next_r.irq[4] = |(next_sts[`TIG_SRC_MEAS +: 2] &
			~next_r.blk[`TIG_SRC_MEAS +: 2]);
		next_r.irq[5] = next_sts[`TIG_SRC_CAP0] &
			~next_r.blk[`TIG_SRC_CAP0];
		next_r.irq[6] = next_sts[`TIG_SRC_CAP3] &
			~next_r.blk[`TIG_SRC_CAP3];
		// the 16..19 block bits live outside this block, so the group
		// here is left unmasked; gate it downstream if needed
		next_r.irq[7] = |next_sts[`TIG_SRC_CAPHI +: 4];
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	// with i_ce low every flop holds, requests of that cycle included
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			r.sts   <= `TIG_STS_RESET;
			r.blk   <= `TIG_BLK_RESET;
			r.rdata <= `TIG_BYTE_ZERO;
			r.irq   <= `TIG_IRQ_RESET;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	// -----------------------------------------------------------------
	// outputs, straight from flops
	// -----------------------------------------------------------------
	assign o_rdata          = r.rdata;
	assign o_irq_pulse_89   = r.irq[0];
	assign o_irq_io_0_3     = r.irq[1];
	assign o_irq_io_4_7     = r.irq[2];
	assign o_irq_io_8_9     = r.irq[3];
	assign o_irq_measure    = r.irq[4];
	assign o_irq_capture0   = r.irq[5];
	assign o_irq_capture3   = r.irq[6];
	assign o_irq_capture_hi = r.irq[7];

endmodule : tig_irq_group

`default_nettype wire

// ==== inc/tig_regs.svh ====
/*
 * register map, field positions and reset values of the timer interrupt
 * group block. Assumes an 8-bit register port with byte addresses.
 */
`ifndef TIG_REGS_SVH
`define TIG_REGS_SVH

// ---------------------------------------------------------------------
// widths
// ---------------------------------------------------------------------
`define TIG_ADDR_W        32
`define TIG_DATA_W        8
`define TIG_NSRC          20
`define TIG_NMASK         16
`define TIG_NGRP          8

// ---------------------------------------------------------------------
// byte addresses
// ---------------------------------------------------------------------
`define TIG_PULSE_D_ADDR  32'h0080_0233
`define TIG_IO_A_ADDR     32'h0080_0234
`define TIG_IO_B_ADDR     32'h0080_0235
`define TIG_IO_C_ADDR     32'h0080_0236
`define TIG_MEAS_ADDR     32'h0080_0237
`define TIG_CAP_A_ADDR    32'h0080_0238
`define TIG_CAP_B_ADDR    32'h0080_0239
`define TIG_CAP_E_ADDR    32'h0080_023C

// ---------------------------------------------------------------------
// field positions inside a byte (bit 7 is the leftmost printed bit)
// ---------------------------------------------------------------------
`define TIG_PAIR_STS_LSB  4
`define TIG_PAIR_BLK_LSB  0
`define TIG_QUAD_STS_LSB  4
`define TIG_QUAD_BLK_LSB  0
`define TIG_ONE_STS_BIT   4
`define TIG_ONE_BLK_BIT   0

// ---------------------------------------------------------------------
// source indices into the status and mask vectors
// ---------------------------------------------------------------------
`define TIG_SRC_PULSE     0
`define TIG_SRC_IO        2
`define TIG_SRC_IO_B      6
`define TIG_SRC_IO_C      10
`define TIG_SRC_MEAS      12
`define TIG_SRC_CAP0      14
`define TIG_SRC_CAP3      15
`define TIG_SRC_CAPHI     16

// ---------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------
`define TIG_STS_RESET     20'h00000
`define TIG_BLK_RESET     16'h0000
`define TIG_BYTE_ZERO     8'h00
`define TIG_IRQ_RESET     8'h00

`endif

// ==== inc/tig_pkg.sv ====
/*
 * types shared by the timer interrupt group block.
 * assumes tig_regs.svh is on the include path.
 */
`default_nettype none
`include "tig_regs.svh"

package tig_pkg;

	// whole state of the block, registered in one place
	typedef struct packed {
		logic [`TIG_NSRC-1:0]   sts;   // sticky request flags
		logic [`TIG_NMASK-1:0]  blk;   // per-source block bits
		logic [`TIG_DATA_W-1:0] rdata; // read answer
		logic [`TIG_NGRP-1:0]   irq;   // group requests
	} tig_state_s;

endpackage : tig_pkg

`default_nettype wire

// ==== bench/tig_src_model.sv ====
/*
 * model of the timer channels that raise requests toward the block.
 * assumes the bench hands it one event vector, one bit per source.
 */
`timescale 1ns/1ps
`default_nettype none
module tig_src_model (
	input  wire logic [19:0] i_ev,    // event vector from the bench
	output logic      [1:0]  o_pulse, // pulse ch 9..8
	output logic      [9:0]  o_io,    // io ch 9..0
	output logic      [1:0]  o_meas,  // measure ch 1..0
	output logic             o_cap0,  // capture ch 0
	output logic             o_cap3,  // capture ch 3
	output logic      [3:0]  o_caphi  // capture ch 19..16
);
	// pulse channel ten has no line here: its flag lives elsewhere
	// these lines are the only way a flag can be set
	assign o_pulse = i_ev[1:0];
	assign o_io    = i_ev[11:2];
	assign o_meas  = i_ev[13:12];
	assign o_cap0  = i_ev[14];
	assign o_cap3  = i_ev[15];
	assign o_caphi = i_ev[19:16];
endmodule : tig_src_model
`default_nettype wire

// ==== bench/tig_irq_chk_assertions.sv ====
/*
 * checker on the ports of the timer interrupt group block.
 * assumes one clock domain and the register map header.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tig_regs.svh"
module tig_irq_chk (
	input wire logic        i_clk,            // clock
	input wire logic        i_arst_n,         // reset, low
	input wire logic        i_ce,             // clock enable
	input wire logic [31:0] i_addr,           // byte address
	input wire logic        i_wr,             // write strobe
	input wire logic        i_rd,             // read strobe
	input wire logic [7:0]  o_rdata,          // read data
	input wire logic [9:0]  i_io_req,         // io requests
	input wire logic [3:0]  i_capture_hi_req, // capture 19..16
	input wire logic        o_irq_io_0_3,     // io 0..3 group
	input wire logic        o_irq_capture_hi  // capture 16..19
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// a taken read; its answer stands in the following cycle only
	sequence s_rd(logic [31:0] a);
		i_ce && i_rd && i_addr == a;
	endsequence
	// a cycle that takes no read leaves zero behind; a frozen cycle holds
	property p_idle;
		$past(i_ce && !i_rd) |-> o_rdata == 8'h00;
	endproperty
	property p_rd_pulse;
		s_rd(`TIG_PULSE_D_ADDR) |=> (o_rdata & 8'hCC) == 8'h00;
	endproperty
	property p_rd_capa;
		s_rd(`TIG_CAP_A_ADDR) |=> (o_rdata & 8'hEE) == 8'h00;
	endproperty
	property p_rd_capb;
		s_rd(`TIG_CAP_B_ADDR) |=> (o_rdata & 8'hEE) == 8'h00;
	endproperty
	property p_rd_cape;
		s_rd(`TIG_CAP_E_ADDR) |=> o_rdata[3:0] == 4'h0;
	endproperty
	property p_rd_none; s_rd(32'h0080_023A) |=> o_rdata == 8'h00; endproperty
	// the capture 16..19 group has no mask inside this block
	property p_hi_set;
		i_ce && |i_capture_hi_req |=> o_irq_capture_hi;
	endproperty
	property p_hi_hold;
		o_irq_capture_hi && !(i_ce && i_wr && i_addr == `TIG_CAP_E_ADDR)
			|=> o_irq_capture_hi;
	endproperty
	// a group request only rises on a request or an unmasking write
	property p_io_rise;
		$rose(o_irq_io_0_3) |-> $past(i_ce && (|i_io_req[3:0] ||
			(i_wr && i_addr == `TIG_IO_A_ADDR)));
	endproperty
	property p_io_fall;
		$fell(o_irq_io_0_3) |-> $past(i_ce && i_wr &&
			i_addr == `TIG_IO_A_ADDR);
	endproperty
	a_idle: assert property (p_idle)
		else $error("read data not idle");
	a_rd_pulse: assert property (p_rd_pulse)
		else $error("pulse empty bits");
	a_rd_capa: assert property (p_rd_capa)
		else $error("cap a reserved");
	a_rd_capb: assert property (p_rd_capb)
		else $error("cap b reserved");
	a_rd_cape: assert property (p_rd_cape)
		else $error("cap e low nibble");
	a_rd_none: assert property (p_rd_none)
		else $error("unmapped read");
	a_hi_set: assert property (p_hi_set)
		else $error("hi group not set");
	a_hi_hold: assert property (p_hi_hold)
		else $error("hi group dropped");
	a_io_rise: assert property (p_io_rise)
		else $error("io group rose");
	a_io_fall: assert property (p_io_fall)
		else $error("io group fell");
endmodule : tig_irq_chk
bind tig_irq_group tig_irq_chk u_chk (
	.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_addr(i_addr),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_io_req(i_io_req),
	.i_capture_hi_req(i_capture_hi_req), .o_irq_io_0_3(o_irq_io_0_3),
	.o_irq_capture_hi(o_irq_capture_hi)
);
`default_nettype wire

// ==== bench/timer_irq_group_status_mask_bench.sv ====
/*
 * self-checking bench of the timer interrupt group block.
 * assumes the block, its header and the source model compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tig_regs.svh"
module timer_irq_group_status_mask_bench;
	typedef struct packed {
		logic [31:0] a;  // register address
		logic [19:0] ev; // sources of this register
		logic [7:0]  m;  // read after writing all ones
		logic [7:0]  s;  // status bits after firing
		logic [2:0]  k;  // group request index
	} tig_row_s;
	// empty and reserved bits must drop out of m and s
	tig_row_s rows [8] = '{
		'{`TIG_PULSE_D_ADDR, 20'h00003, 8'h03, 8'h30, 3'h0},
		'{`TIG_IO_A_ADDR, 20'h0003C, 8'h0F, 8'hF0, 3'h1},
		'{`TIG_IO_B_ADDR, 20'h003C0, 8'h0F, 8'hF0, 3'h2},
		'{`TIG_IO_C_ADDR, 20'h00C00, 8'h03, 8'h30, 3'h3},
		'{`TIG_MEAS_ADDR, 20'h03000, 8'h03, 8'h30, 3'h4},
		'{`TIG_CAP_A_ADDR, 20'h04000, 8'h01, 8'h10, 3'h5},
		'{`TIG_CAP_B_ADDR, 20'h08000, 8'h01, 8'h10, 3'h6},
		'{`TIG_CAP_E_ADDR, 20'hF0000, 8'h00, 8'hF0, 3'h7}
	};
	logic        i_clk, i_arst_n, i_ce, i_wr, i_rd;
	logic [31:0] i_addr;
	logic [7:0]  i_wdata, o_rdata, irqv;
	logic [19:0] ev;
	logic [1:0]  pulse, meas;
	logic [9:0]  io;
	logic [3:0]  chi;
	logic        c0, c3;
	int          n_mismatch = 0, num_checks = 0, cyc = 0;
	tig_src_model SRC (.i_ev(ev), .o_pulse(pulse), .o_io(io),
		.o_meas(meas), .o_cap0(c0), .o_cap3(c3), .o_caphi(chi));
	tig_irq_group DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_pulse_req(pulse), .i_io_req(io),
		.i_measure_req(meas), .i_capture0_req(c0), .i_capture3_req(c3),
		.i_capture_hi_req(chi), .o_irq_pulse_89(irqv[0]),
		.o_irq_io_0_3(irqv[1]), .o_irq_io_4_7(irqv[2]),
		.o_irq_io_8_9(irqv[3]), .o_irq_measure(irqv[4]),
		.o_irq_capture0(irqv[5]), .o_irq_capture3(irqv[6]),
		.o_irq_capture_hi(irqv[7]));
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	task print_verdict;
		if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict
	// a run far past the expected two hundred or so cycles counts as a hang
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// one strobe cycle; released at the edge that takes it
	task bus(input logic w, input logic [31:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= w;
		i_rd <= !w;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
	endtask : bus
	task rd(input logic [31:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		#1 chk(o_rdata, e);
	endtask : rd
	task fire(input logic [19:0] v);
		@(posedge i_clk);
		ev <= v;
		@(posedge i_clk);
		ev <= 20'h0;
		#1;
	endtask : fire
	initial begin
		{i_arst_n, i_wr, i_rd, i_addr, i_wdata, ev} = '0;
		i_ce = 1'b1;
		repeat (12) @(posedge i_clk);
		i_arst_n <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i].a, 8'h00);
			bus(1'b1, rows[i].a, 8'hFF);
			rd(rows[i].a, rows[i].m);
			fire(rows[i].ev);
			chk(irqv, rows[i].k == 3'h7 ? 8'h80 : 8'h00);
			rd(rows[i].a, rows[i].m | rows[i].s);
			bus(1'b1, rows[i].a, 8'h00);
			rd(rows[i].a, 8'h00);
			fire(rows[i].ev);
			chk(irqv, 8'h01 << rows[i].k);
			bus(1'b1, rows[i].a, 8'h00);
		end
		rd(32'h0080_023A, 8'h00);
		// reserved mask positions set, real masks open: requests pass
		bus(1'b1, `TIG_CAP_A_ADDR, 8'h16);
		bus(1'b1, `TIG_CAP_B_ADDR, 8'h1E);
		fire(20'h0C000);
		chk(irqv, 8'h60);
		bus(1'b1, `TIG_CAP_A_ADDR, 8'h00);
		bus(1'b1, `TIG_CAP_B_ADDR, 8'h00);
		// a partial clear keeps the unserviced flags pending
		fire(20'h0003C);
		bus(1'b1, `TIG_IO_A_ADDR, 8'h70);
		rd(`TIG_IO_A_ADDR, 8'h70);
		chk(irqv, 8'h02);
		// a request in the clearing cycle must not be lost
		@(posedge i_clk);
		ev <= 20'h00004;
		i_wr <= 1'b1;
		i_addr <= `TIG_IO_A_ADDR;
		i_wdata <= 8'h00;
		@(posedge i_clk);
		ev <= 20'h0;
		i_wr <= 1'b0;
		rd(`TIG_IO_A_ADDR, 8'h10);
		// with the clock enable low a request is dropped
		@(posedge i_clk);
		i_ce <= 1'b0;
		ev <= 20'hF0000;
		@(posedge i_clk);
		i_ce <= 1'b1;
		ev <= 20'h0;
		rd(`TIG_CAP_E_ADDR, 8'h00);
		// reset in mid-run wipes flags and masks alike
		bus(1'b1, `TIG_IO_B_ADDR, 8'h0F);
		@(posedge i_clk);
		i_arst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1'b1;
		rd(`TIG_IO_A_ADDR, 8'h00);
		rd(`TIG_IO_B_ADDR, 8'h00);
		chk(irqv, 8'h00);
		print_verdict();
	end
endmodule : timer_irq_group_status_mask_bench
`default_nettype wire
